// file: sacc_pkg.sv
package sacc_pkg;

    // ********************************
    // widths
    // ********************************
    localparam int RESULT_BITS = 10;
    localparam int MUX_BITS    = 6;

    // ********************************
    // selection codes
    // ********************************
    localparam logic [5:0] TEMP_SENSOR_CODE = 6'h22;
    localparam logic [1:0] REF_SUPPLY       = 2'h0;
    localparam logic [1:0] REF_EXTERNAL     = 2'h1;
    localparam logic [1:0] REF_INTERNAL     = 2'h2;
    localparam logic [2:0] TRIG_DONE_FLAG   = 3'h0;

    // ********************************
    // timing in converter cycles, half cycles (X2 names), CPU cycles and clock rates
    // ********************************
    localparam int NORMAL_CYCLES     = 13;
    localparam int FIRST_CYCLES      = 25;
    localparam int AUTO_CYCLES_X2    = 27;
    localparam int NORMAL_SAMPLE_X2  = 3;
    localparam int FIRST_SAMPLE_X2   = 29;
    localparam int AUTO_SAMPLE_X2    = 4;
    localparam int SYNC_CPU_CYCLES   = 3;
    localparam int CLOCK_HZ          = 20000000;
    localparam int CONV_CLK_MIN_HZ   = 50000;
    localparam int CONV_CLK_MAX_HZ   = 200000;

    // ********************************
    // reset values
    // ********************************
    localparam logic [9:0] RESULT_RESET = 10'h000;

    typedef enum logic [1:0]
    {
        SACC_IDLE  = 2'b00,
        SACC_SYNC  = 2'b01,
        SACC_CONV  = 2'b11,
        SACC_DONE  = 2'b10
    } sacc_state_type;

endpackage

// file: sacc_prescaler.sv
`timescale 1ns/1ps
module sacc_prescaler
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // control
    input  wire logic       i_enable,
    input  wire logic       i_restart,
    input  wire logic [2:0] i_prescaler_select,
    // half-period enables
    output logic            o_rise,
    output logic            o_fall
);
    logic [6:0] count;
    logic [6:0] limit;

    // divide by 2..128, select 0 behaves as 1
    always_comb
    begin
        limit = (i_prescaler_select == 3'h0) ? 7'h01 :
                7'((8'h01 << i_prescaler_select) - 8'h01);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset || !i_enable || i_restart)
            count <= 7'h00;
        else if (count == limit)
            count <= 7'h00;
        else
            count <= count + 7'h01;
    end

    assign o_rise = i_enable && !i_restart && (count == limit);
    assign o_fall = i_enable && !i_restart && (count == 7'((limit >> 1)));
endmodule // sacc_prescaler

// file: sacc_sar.sv
`timescale 1ns/1ps
module sacc_sar
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // control
    input  wire logic       i_start,
    input  wire logic       i_step,
    // comparator
    input  wire logic       i_compare,
    // trial code and result
    output logic [9:0]      o_trial,
    output logic [9:0]      o_code
);
    logic [9:0] bit_mask;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            bit_mask <= 10'h000;
            o_trial  <= 10'h000;
            o_code   <= 10'h000;
        end
        else if (i_start)
        begin
            bit_mask <= 10'h200;
            o_trial  <= 10'h200;
        end
        else if (i_step && bit_mask != 10'h000)
        begin
            if (bit_mask == 10'h001)
                o_code <= i_compare ? o_trial : (o_trial & ~bit_mask);
            bit_mask <= bit_mask >> 1;
            o_trial  <= (i_compare ? o_trial : (o_trial & ~bit_mask)) | (bit_mask >> 1);
        end
    end
endmodule // sacc_sar

// file: sacc_control.sv
`timescale 1ns/1ps
module sacc_control
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // control bits
    input  wire logic       i_converter_enable,
    input  wire logic       i_auto_trigger_enable,
    input  wire logic [2:0] i_trigger_source_select,
    input  wire logic [2:0] i_prescaler_select,
    input  wire logic       i_left_adjust_result,
    input  wire logic [1:0] i_reference_select,
    input  wire logic [5:0] i_input_select_field,
    input  wire logic       i_start_write,
    input  wire logic       i_done_flag_clear,
    // result reads
    input  wire logic       i_low_read,
    input  wire logic       i_high_read,
    // trigger events
    input  wire logic [7:0] i_trigger_events,
    // analog array
    input  wire logic       i_compare,
    output logic            o_analog_power,
    output logic            o_sample,
    output logic [9:0]      o_trial,
    output logic [1:0]      o_active_reference,
    output logic [5:0]      o_active_channel,
    output logic            o_gain_20x,
    output logic            o_differential,
    output logic            o_temp_sensor,
    // status
    output logic            o_start_conversion_bit,
    output logic            o_conversion_done_flag,
    output logic [7:0]      o_result_high_byte,
    output logic [7:0]      o_result_low_byte
);
    sacc_pkg::sacc_state_type state;
    logic [5:0] half_count;
    logic [5:0] end_half;
    logic [5:0] sample_half;
    logic       first_done;
    logic       blocked;
    logic       trig_prev;
    logic       trig_now;
    logic       trig_edge;
    logic [1:0] sync_count;
    logic       auto_run;
    logic       pending;
    logic       half_tick;
    logic       rise;
    logic       fall;
    logic       restart;
    logic       sar_start;
    logic       finish;
    logic       sar_step;
    logic       free_run;
    logic [9:0] code;
    logic [15:0] adjusted;

    // ********************************
    // trigger selection
    // ********************************
    // parameterless index over events
    always_comb
    begin
        trig_now = (i_trigger_source_select == sacc_pkg::TRIG_DONE_FLAG) ?
                   o_conversion_done_flag : i_trigger_events[i_trigger_source_select];
    end

    // edge detect; a source must fall before a new edge can appear; the done flag source never gives an edge
    assign trig_edge = i_auto_trigger_enable && trig_now && !trig_prev &&
                       (i_trigger_source_select != sacc_pkg::TRIG_DONE_FLAG);

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            trig_prev <= 1'b0;
        else
            trig_prev <= trig_now;
    end

    // ********************************
    // prescaler
    // ********************************
    // trigger restarts the divider for fixed latency
    assign restart = (state == sacc_pkg::SACC_IDLE) && trig_edge && i_converter_enable;

    sacc_prescaler u_prescaler
    (
        .i_clk              (i_clk),
        .i_reset            (i_reset),
        .i_enable           (i_converter_enable),
        .i_restart          (restart),
        .i_prescaler_select (i_prescaler_select),
        .o_rise             (rise),
        .o_fall             (fall)
    );

    assign half_tick = rise || fall;

    // ********************************
    // conversion sequencer
    // ********************************
    assign finish = (state == sacc_pkg::SACC_CONV) && half_tick && (half_count == end_half);

    always_ff @(posedge i_clk)
    begin
        if (i_reset || !i_converter_enable)
        begin
            state      <= sacc_pkg::SACC_IDLE;
            half_count <= 6'h00;
            end_half   <= 6'h00;
            sample_half <= 6'h00;
            sync_count <= 2'h0;
            auto_run   <= 1'b0;
        end
        else
        begin
            unique case (state)
                sacc_pkg::SACC_IDLE:
                begin
                    // synchronisation cycles before the trigger conversion
                    if (restart)
                    begin
                        state      <= sacc_pkg::SACC_SYNC;
                        sync_count <= 2'(sacc_pkg::SYNC_CPU_CYCLES - 1);
                        auto_run   <= 1'b1;
                    end
                    // manual start waits for the converter clock rise
                    else if (pending && rise)
                    begin
                        state       <= sacc_pkg::SACC_CONV;
                        half_count  <= 6'h00;
                        auto_run    <= 1'b0;
                        end_half    <= first_done ? 6'(2 * sacc_pkg::NORMAL_CYCLES - 1) :
                                                    6'(2 * sacc_pkg::FIRST_CYCLES - 1);
                        sample_half <= first_done ? 6'(sacc_pkg::NORMAL_SAMPLE_X2) :
                                                    6'(sacc_pkg::FIRST_SAMPLE_X2);
                    end
                end
                sacc_pkg::SACC_SYNC:
                begin
                    if (sync_count == 2'h0)
                    begin
                        state       <= sacc_pkg::SACC_CONV;
                        half_count  <= 6'h00;
                        end_half    <= first_done ? 6'(sacc_pkg::AUTO_CYCLES_X2 - 1) :
                                                    6'(2 * sacc_pkg::FIRST_CYCLES - 1);
                        sample_half <= first_done ? 6'(sacc_pkg::AUTO_SAMPLE_X2) :
                                                    6'(sacc_pkg::FIRST_SAMPLE_X2);
                    end
                    else
                        sync_count <= sync_count - 2'h1;
                end
                sacc_pkg::SACC_CONV:
                begin
                    if (finish)
                        state <= sacc_pkg::SACC_DONE;
                    else if (half_tick)
                        half_count <= half_count + 6'h01;
                end
                sacc_pkg::SACC_DONE:
                begin
                    // free running restarts on the next converter clock rise in idle; held trigger ignored
                    state <= sacc_pkg::SACC_IDLE;
                end
            endcase
        end
    end

    // the long first conversion is needed once per enable
    always_ff @(posedge i_clk)
    begin
        if (i_reset || !i_converter_enable)
            first_done <= 1'b0;
        else if (finish)
            first_done <= 1'b1;
    end

    // ********************************
    // start bit
    // ********************************
    // write sets, hardware clears; one during a conversion up to its completion cycle
    always_ff @(posedge i_clk)
    begin
        if (i_reset || !i_converter_enable)
            pending <= 1'b0;
        else if (i_start_write)
            pending <= 1'b1;
        else if (state == sacc_pkg::SACC_DONE && i_auto_trigger_enable &&
                 i_trigger_source_select == sacc_pkg::TRIG_DONE_FLAG)
            // free running keeps the start bit high
            pending <= 1'b1;
        else if (state == sacc_pkg::SACC_CONV && rise && !auto_run)
            pending <= 1'b0;
    end

    // free running keeps the start bit up through completion
    assign free_run = i_auto_trigger_enable &&
                      (i_trigger_source_select == sacc_pkg::TRIG_DONE_FLAG);

    // start bit drops in the completion cycle of a single conversion
    assign o_start_conversion_bit = (pending || state == sacc_pkg::SACC_SYNC ||
                                    (state == sacc_pkg::SACC_CONV && (!finish || free_run)) ||
                                    (state == sacc_pkg::SACC_DONE && free_run)) &&
                                    i_converter_enable;

    // ********************************
    // done flag
    // ********************************
    // raised even when the result is dropped; set wins over clear
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_conversion_done_flag <= 1'b0;
        else if (finish)
            o_conversion_done_flag <= 1'b1;
        else if (i_done_flag_clear)
            o_conversion_done_flag <= 1'b0;
    end

    // ********************************
    // selection latch
    // ********************************
    // copy until start, resume in the last cycle
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_active_reference <= sacc_pkg::REF_SUPPLY;
            o_active_channel   <= 6'h00;
        end
        else if (i_converter_enable && (state == sacc_pkg::SACC_IDLE ||
                 (state == sacc_pkg::SACC_CONV && half_count >= end_half - 6'h01)))
        begin
            o_active_reference <= i_reference_select;
            o_active_channel   <= i_input_select_field;
        end
    end

    // pair codes from eight up except the temperature code, gain from the low bit
    assign o_differential = (o_active_channel >= 6'h08) &&
                            (o_active_channel != sacc_pkg::TEMP_SENSOR_CODE);
    assign o_gain_20x     = o_differential && o_active_channel[0];
    assign o_temp_sensor  = (o_active_channel == sacc_pkg::TEMP_SENSOR_CODE);
    assign o_analog_power = i_converter_enable;

    // ********************************
    // analog array
    // ********************************
    // one-cycle sample strobe
    assign o_sample  = (state == sacc_pkg::SACC_CONV) && half_tick &&
                       (half_count == sample_half);
    assign sar_start = o_sample;

    // step on the half opposite the sample, so the last step
    // lands before completion even in the short tail of a first conversion
    assign sar_step  = (state == sacc_pkg::SACC_CONV) && half_tick &&
                       (half_count[0] != sample_half[0]);

    sacc_sar u_sar
    (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_start   (sar_start),
        .i_step    (sar_step),
        .i_compare (i_compare),
        .o_trial   (o_trial),
        .o_code    (code)
    );

    // ********************************
    // result registers
    // ********************************
    // alignment choice
    assign adjusted = i_left_adjust_result ? {code, 6'h00} : {6'h00, code};

    // low read locks until the high read
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            blocked <= 1'b0;
        else if (i_low_read)
            blocked <= 1'b1;
        else if (i_high_read)
            blocked <= 1'b0;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_result_high_byte <= 8'h00;
            o_result_low_byte  <= 8'h00;
        end
        else if (finish && !blocked)
        begin
            o_result_high_byte <= adjusted[15:8];
            o_result_low_byte  <= adjusted[7:0];
        end
    end
endmodule // sacc_control

// file: sacc_monitor.sv
`timescale 1ns/1ps
module sacc_monitor
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // watched inputs
    input  wire logic       i_converter_enable,
    input  wire logic       i_auto_trigger_enable,
    input  wire logic       i_done_flag_clear,
    input  wire logic       i_low_read,
    input  wire logic       i_high_read,
    // watched outputs
    input  wire logic       o_analog_power,
    input  wire logic       o_sample,
    input  wire logic [5:0] o_active_channel,
    input  wire logic       o_gain_20x,
    input  wire logic       o_differential,
    input  wire logic       o_temp_sensor,
    input  wire logic       o_start_conversion_bit,
    input  wire logic       o_conversion_done_flag,
    input  wire logic [7:0] o_result_low_byte
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // ********************************
    // result lock tracking
    // ********************************
    logic blocked;
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            blocked <= 1'b0;
        else if (i_low_read)
            blocked <= 1'b1;
        else if (i_high_read)
            blocked <= 1'b0;
    end

    chk_power_follow: assert property (o_analog_power == i_converter_enable)
        else $error("analog power not following enable");
    chk_idle_when_off: assert property (!i_converter_enable && !$past(i_converter_enable)
        |-> !o_sample && !o_start_conversion_bit)
        else $error("activity while disabled");
    chk_sample_busy: assert property (o_sample |-> o_start_conversion_bit)
        else $error("sample outside a conversion");
    chk_select_held: assert property (o_sample |=> $stable(o_active_channel) [*8])
        else $error("channel moved during conversion");
    chk_temp_decode: assert property
        (o_temp_sensor == (o_active_channel == sacc_pkg::TEMP_SENSOR_CODE))
        else $error("temperature route wrong");
    chk_diff_decode: assert property (o_differential ==
        (o_active_channel >= 6'h08 && o_active_channel != sacc_pkg::TEMP_SENSOR_CODE))
        else $error("differential decode wrong");
    chk_gain_pair: assert property (o_gain_20x |-> o_differential && o_active_channel[0])
        else $error("gain on a single ended channel");
    chk_result_lock: assert property (blocked && !i_high_read |=> $stable(o_result_low_byte))
        else $error("result changed while blocked");
    chk_single_clear: assert property ($rose(o_conversion_done_flag) && !i_auto_trigger_enable
        |-> !o_start_conversion_bit)
        else $error("start bit high at single completion");
    chk_flag_stands: assert property (o_conversion_done_flag && !i_done_flag_clear
        && i_converter_enable |=> o_conversion_done_flag)
        else $error("done flag dropped without clear");

    cover property ($rose(o_conversion_done_flag) && i_auto_trigger_enable);
    cover property (blocked && $rose(o_conversion_done_flag));
    cover property (o_sample && o_temp_sensor);
endmodule // sacc_monitor

bind sacc_control sacc_monitor u_monitor
(
    .i_clk(i_clk), .i_reset(i_reset), .i_converter_enable(i_converter_enable),
    .i_auto_trigger_enable(i_auto_trigger_enable), .i_done_flag_clear(i_done_flag_clear),
    .i_low_read(i_low_read), .i_high_read(i_high_read), .o_analog_power(o_analog_power),
    .o_sample(o_sample), .o_active_channel(o_active_channel), .o_gain_20x(o_gain_20x),
    .o_differential(o_differential), .o_temp_sensor(o_temp_sensor),
    .o_start_conversion_bit(o_start_conversion_bit),
    .o_conversion_done_flag(o_conversion_done_flag), .o_result_low_byte(o_result_low_byte)
);

// file: sacc_analog_model.sv
`timescale 1ns/1ps
module sacc_analog_model
(
    // clock
    input  wire logic       i_clk,
    // array side
    input  wire logic       i_sample,
    input  wire logic [9:0] i_trial,
    input  wire logic [9:0] i_level,
    output logic            o_compare
);
    logic [9:0] held;
    always_ff @(posedge i_clk)
    begin
        if (i_sample)
            held <= i_level;
    end
    assign o_compare = (i_trial <= (i_sample ? i_level : held));
endmodule // sacc_analog_model

// file: sacc_control_bench.sv
`timescale 1ns/1ps
module sacc_control_bench;
    // ********************************
    // signals
    // ********************************
    logic       i_clk, i_reset, en, auto_en, ladj, start, clr, lrd, hrd, cmp;
    logic [2:0] trig_sel, psel;
    logic [1:0] ref_sel, act_ref;
    logic [5:0] ch_sel, act_ch;
    logic [7:0] events, rh, rl;
    logic [9:0] level, trial;
    logic       power, sample, gain, diff, temp, sbit, flag;
    logic [15:0] exp;
    int         n, mismatches, samples_checked;

    sacc_control dut
    (
        .i_clk(i_clk), .i_reset(i_reset), .i_converter_enable(en),
        .i_auto_trigger_enable(auto_en), .i_trigger_source_select(trig_sel),
        .i_prescaler_select(psel), .i_left_adjust_result(ladj), .i_reference_select(ref_sel),
        .i_input_select_field(ch_sel), .i_start_write(start), .i_done_flag_clear(clr),
        .i_low_read(lrd), .i_high_read(hrd), .i_trigger_events(events), .i_compare(cmp),
        .o_analog_power(power), .o_sample(sample), .o_trial(trial),
        .o_active_reference(act_ref), .o_active_channel(act_ch), .o_gain_20x(gain),
        .o_differential(diff), .o_temp_sensor(temp), .o_start_conversion_bit(sbit),
        .o_conversion_done_flag(flag), .o_result_high_byte(rh), .o_result_low_byte(rl)
    );
    sacc_analog_model u_array
    (
        .i_clk(i_clk), .i_sample(sample), .i_trial(trial), .i_level(level), .o_compare(cmp)
    );

    // ********************************
    // helpers
    // ********************************
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic results();
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    // start, clear, low read, high read
    task automatic pulse(input logic [3:0] k);
        {start, clr, lrd, hrd} = k;
        @(negedge i_clk);
        {start, clr, lrd, hrd} = 4'h0;
        @(negedge i_clk);
    endtask
    // bounded wait, so a stuck sequencer cannot hang the run
    task automatic run(input logic st, output int c);
        start = st;
        c = 0;
        while (flag !== 1'b1 && c < 400)
        begin
            @(negedge i_clk);
            start = 1'b0;
            c++;
        end
    endtask
    task automatic win(input int c, input int lo, input int hi);
        check({15'h0, c >= lo && c <= hi}, 16'h0001);
    endtask
    function automatic logic [15:0] align(input logic [9:0] c, input logic l);
        align = l ? {c, 6'h00} : {6'h00, c};
    endfunction
    function automatic logic [1:0] decode(input logic [5:0] c);
        logic d;
        d = c >= 6'h08 && c != sacc_pkg::TEMP_SENSOR_CODE;
        decode = {d, d & c[0]};
    endfunction

    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial
    begin
        #(50 * 5000);
        mismatches++;
        results();
    end

    // ********************************
    // scenarios
    // ********************************
    initial
    begin
        {en, auto_en, ladj, start, clr, lrd, hrd} = 7'h00;
        {trig_sel, psel, ref_sel, ch_sel, events, level} = 32'h0;
        trig_sel = 3'h1;
        i_reset = 1'b1;
        void'($urandom(32'h164F));
        cyc(2);
        i_reset = 1'b0;
        check({rh, rl}, 16'h0000);
        pulse(4'h8);
        cyc(60);
        check({14'h0, sbit, flag}, 16'h0000);
        check({15'h0, power}, 16'h0000);
        en = 1'b1;
        for (int r = 0; r < 3; r++)
        begin
            ref_sel = r[1:0];
            cyc(3);
            check({14'h0, act_ref}, {14'h0, r[1:0]});
        end
        check({15'h0, power}, 16'h0001);
        repeat (8)
        begin
            ch_sel = 6'($urandom());
            cyc(3);
            check({14'h0, diff, gain}, {14'h0, decode(ch_sel)});
        end
        // first conversion after enable is the long one
        ch_sel = 6'h05;
        level = 10'($urandom());
        cyc(2);
        run(1'b1, n);
        win(n, 46, 56);
        check({rh, rl}, align(level, 1'b0));
        check({15'h0, sbit}, 16'h0000);
        pulse(4'h4);
        ladj = 1'b1;
        level = 10'($urandom());
        fork
            run(1'b1, n);
            begin
                cyc(6);
                ch_sel = sacc_pkg::TEMP_SENSOR_CODE;
                cyc(4);
                check({10'h0, act_ch}, 16'h0005);
            end
        join
        win(n, 22, 32);
        check({rh, rl}, align(level, 1'b1));
        cyc(2);
        check({15'h0, temp}, 16'h0001);
        // low read locks out the next result
        pulse(4'h4);
        exp = align(level, 1'b1);
        pulse(4'h2);
        level = 10'($urandom());
        run(1'b1, n);
        win(n, 22, 32);
        check({rh, rl}, exp);
        pulse(4'h5);
        run(1'b1, n);
        check({rh, rl}, align(level, 1'b1));
        pulse(4'h4);
        // auto trigger, all sources high
        ladj = 1'b0;
        auto_en = 1'b1;
        level = 10'($urandom());
        cyc(5);
        events = 8'hFF;
        fork
            run(1'b0, n);
            begin
                cyc(8);
                events = 8'h00;
                cyc(2);
                events = 8'hFF;
            end
        join
        win(n, 26, 36);
        check({rh, rl}, align(level, 1'b0));
        pulse(4'h4);
        cyc(80);
        check({14'h0, sbit, flag}, 16'h0000);
        run(1'b1, n);
        win(n, 22, 32);
        events = 8'h00;
        pulse(4'h4);
        // free running off the done flag, flag left set
        trig_sel = sacc_pkg::TRIG_DONE_FLAG;
        run(1'b1, n);
        win(n, 22, 32);
        level = 10'($urandom());
        cyc(60);
        check({rh, rl}, align(level, 1'b0));
        check({15'h0, sbit}, 16'h0001);
        auto_en = 1'b0;
        cyc(40);
        check({15'h0, sbit}, 16'h0000);
        // disable and enable again: the long first conversion returns
        en = 1'b0;
        cyc(4);
        check({14'h0, sbit, power}, 16'h0000);
        en = 1'b1;
        level = 10'($urandom());
        pulse(4'h4);
        run(1'b1, n);
        win(n, 46, 56);
        check({rh, rl}, align(level, 1'b0));
        results();
    end
endmodule // sacc_control_bench
